/* File: src/smcfg_defs.vh */
/*
 * Constants for the serial mode configuration block: register offsets,
 * field positions, reset values, decode codes and prescaler ratios.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SMCFG_DEFS_VH
`define SMCFG_DEFS_VH

// Register byte offsets on the bus
`define SMCFG_ADR_MODE      4'h0
`define SMCFG_ADR_SCSEL     4'h4
`define SMCFG_ADR_STATUS    4'h8
`define SMCFG_ADR_W         4

// Reset values
`define SMCFG_MODE_RST      8'h00
`define SMCFG_SCSEL_RST     1'b0

// Field positions, shared by both layouts where noted
`define SMCFG_B_TOP         7
`define SMCFG_B_SIX         6
`define SMCFG_B_PAR_EN      5
`define SMCFG_B_PAR_ODD     4
`define SMCFG_B_STOP        3
`define SMCFG_B_BCP_HI      3
`define SMCFG_B_MP          2
`define SMCFG_B_BCP_LO      2
`define SMCFG_B_CKS_HI      1
`define SMCFG_B_CKS_LO      0

// Bit-period codes and the S value for each
`define SMCFG_BCP_32        2'h0
`define SMCFG_BCP_64        2'h1
`define SMCFG_BCP_372       2'h2
`define SMCFG_BCP_256       2'h3
`define SMCFG_S_32          9'h020
`define SMCFG_S_64          9'h040
`define SMCFG_S_372         9'h174
`define SMCFG_S_256         9'h100

// Prescaler codes and their terminal counts (ratio minus one)
`define SMCFG_CKS_DIV1      2'h0
`define SMCFG_CKS_DIV4      2'h1
`define SMCFG_CKS_DIV16     2'h2
`define SMCFG_CKS_DIV64     2'h3
`define SMCFG_TC_DIV4       6'h03
`define SMCFG_TC_DIV16      6'h0f
`define SMCFG_TC_DIV64      6'h3f
`define SMCFG_PRE_ZERO      6'h00
`define SMCFG_PRE_ONE       6'h01

// Transmit-end advance in elementary time units, times ten
`define SMCFG_GSM_ADV_X10   8'h6e
`define SMCFG_ZERO8         8'h00

// Idle read data, also its reset value
`define SMCFG_DAT_ZERO      32'h00000000

`endif

/* File: src/smcfg_prescale.v */
/*
 * Baud-generator source prescaler: emits a one-cycle tick at the
 * system clock divided by 1, 4, 16 or 64 as chosen by the clock select.
 * Assumes a synchronous active-high reset on the system clock.
 */
`timescale 1ns/1ns
`include "smcfg_defs.vh"

module smcfg_prescale (
    input  wire       clk_i,    // System clock
    input  wire       rst_i,    // Synchronous reset
    input  wire [1:0] cks_i,    // Clock select code
    output reg        tick_o    // Prescaled clock tick
);

    reg  [5:0] cnt_reg;         // Free-running divider count
    reg  [5:0] term;            // Terminal count for this ratio

    // Terminal count from the select code
    always @* begin
        case (cks_i)
            `SMCFG_CKS_DIV4:  term = `SMCFG_TC_DIV4;
            `SMCFG_CKS_DIV16: term = `SMCFG_TC_DIV16;
            `SMCFG_CKS_DIV64: term = `SMCFG_TC_DIV64;
            default:          term = `SMCFG_PRE_ZERO;   // Undivided
        endcase
    end

    // Divider and tick; a ratio change restarts cleanly at terminal
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= `SMCFG_PRE_ZERO;
            tick_o  <= 1'b0;
        end else if (cnt_reg >= term) begin
            cnt_reg <= `SMCFG_PRE_ZERO;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + `SMCFG_PRE_ONE;
            tick_o  <= 1'b0;
        end
    end

endmodule

/* File: src/smcfg_decode.v */
/*
 * Layout decoder: turns the raw mode byte and the interface select into
 * the per-function controls for transmitter, receiver and rate generator.
 * Purely combinational; the top registers every result.
 */
`timescale 1ns/1ns
`include "smcfg_defs.vh"

module smcfg_decode (
    input  wire [7:0] mode_i,         // Raw mode register
    input  wire       sc_sel_i,       // Smart card layout select
    output reg        sync_o,         // Clocked synchronous mode
    output reg        char7_o,        // Seven-bit characters
    output reg        stop2_o,        // Two stop bits
    output reg        mp_o,           // Multiprocessor function active
    output reg        par_en_o,       // Parity added and checked
    output reg        par_odd_o,      // Odd parity
    output reg        gsm_o,          // GSM timing and clock modes
    output reg        blk_o,          // Block transfer operation
    output reg  [8:0] s_o,            // Basic clocks per bit
    output reg  [1:0] cks_o           // Clock source select
);

    // Map the bit period code to S
    function [8:0] bcp_to_s;
        input [1:0] code;
        begin
            case (code)
                `SMCFG_BCP_64:  bcp_to_s = `SMCFG_S_64;
                `SMCFG_BCP_372: bcp_to_s = `SMCFG_S_372;
                `SMCFG_BCP_256: bcp_to_s = `SMCFG_S_256;
                default:        bcp_to_s = `SMCFG_S_32;
            endcase
        end
    endfunction

    // Field meaning follows the interface select
    always @* begin
        cks_o     = {mode_i[`SMCFG_B_CKS_HI], mode_i[`SMCFG_B_CKS_LO]};
        par_en_o  = 1'b0;
        par_odd_o = 1'b0;
        sync_o    = 1'b0;
        char7_o   = 1'b0;
        stop2_o   = 1'b0;
        mp_o      = 1'b0;
        gsm_o     = 1'b0;
        blk_o     = 1'b0;
        s_o       = `SMCFG_S_32;
        if (sc_sel_i) begin
            // Smart card: GSM, block, parity, bit period
            gsm_o     = mode_i[`SMCFG_B_TOP];
            blk_o     = mode_i[`SMCFG_B_SIX];
            par_en_o  = mode_i[`SMCFG_B_PAR_EN];
            par_odd_o = mode_i[`SMCFG_B_PAR_EN] & mode_i[`SMCFG_B_PAR_ODD];
            s_o       = bcp_to_s({mode_i[`SMCFG_B_BCP_HI], mode_i[`SMCFG_B_BCP_LO]});
        end else begin
            // Normal layout
            sync_o  = mode_i[`SMCFG_B_TOP];
            char7_o = ~mode_i[`SMCFG_B_TOP] & mode_i[`SMCFG_B_SIX];
            stop2_o = ~mode_i[`SMCFG_B_TOP] & mode_i[`SMCFG_B_STOP];
            mp_o    = ~mode_i[`SMCFG_B_TOP] & mode_i[`SMCFG_B_MP];
            // Parity only in async and never with multiprocessor
            if (!mode_i[`SMCFG_B_TOP] && !mode_i[`SMCFG_B_MP]) begin
                par_en_o  = mode_i[`SMCFG_B_PAR_EN];
                par_odd_o = mode_i[`SMCFG_B_PAR_EN] & mode_i[`SMCFG_B_PAR_ODD];
            end
        end
    end

endmodule

/* File: src/smcfg_top.v */
/*
 * Serial mode configuration block: the mode register and the smart card
 * layout select on a classic Wishbone slave, with decoded, registered
 * controls for the transmitter, receiver and bit-rate generator.
 * Assumes one system clock and a synchronous active-high reset; the
 * transmitter and receiver themselves live outside this block.
 */
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
`include "smcfg_defs.vh"

module smcfg_top (
    input  wire        clk_i,          // System clock, 50 MHz
    input  wire        rst_i,          // Synchronous reset
    input  wire        cyc_i,          // Wishbone cycle
    input  wire        stb_i,          // Wishbone strobe
    input  wire        we_i,           // Wishbone write
    input  wire [3:0]  adr_i,          // Wishbone byte address
    input  wire [3:0]  sel_i,          // Wishbone byte selects
    input  wire [31:0] dat_i,          // Wishbone write data
    output reg  [31:0] dat_o,          // Wishbone read data
    output reg         ack_o,          // Wishbone acknowledge
    output reg         err_o,          // Unmapped address answer
    output reg         sync_o,         // Clocked synchronous mode
    output reg         char7_o,        // Seven-bit characters
    output reg         stop2_o,        // Two stop bits
    output reg         mp_en_o,        // Multiprocessor function on
    output reg         parity_en_o,    // Parity add and check
    output reg         parity_odd_o,   // Odd parity
    output reg         gsm_timing_en_o,// Early transmit end, extra clock modes
    output reg         block_xfer_en_o,// Block transfer operation
    output reg  [8:0]  bit_period_o,   // Basic clocks per bit (S)
    output reg  [1:0]  clk_sel_o,      // Clock select index n
    output reg  [7:0]  tx_end_adv_x10_o, // Transmit-end advance, etu x10
    output reg         baud_tick_o     // Prescaled source tick
);

    // Software-visible state
    reg  [7:0] serial_mode_register;   // Mode register
    reg        smartcard_if_sel;       // Layout select

    // Decoder results
    wire       dec_sync;               // Synchronous mode
    wire       dec_char7;              // Seven-bit characters
    wire       dec_stop2;              // Two stop bits
    wire       dec_mp;                 // Multiprocessor on
    wire       dec_par_en;             // Parity on
    wire       dec_par_odd;            // Odd parity
    wire       dec_gsm;                // GSM timing
    wire       dec_blk;                // Block transfer
    wire [8:0] dec_s;                  // S value
    wire [1:0] dec_cks;                // Clock select
    wire       pre_tick;               // Prescaler tick

    // Bus request decode
    wire       req     = cyc_i & stb_i & ~ack_o & ~err_o;
    wire       hit_mode  = (adr_i == `SMCFG_ADR_MODE);
    wire       hit_scsel = (adr_i == `SMCFG_ADR_SCSEL);
    wire       hit_stat  = (adr_i == `SMCFG_ADR_STATUS);
    wire       hit     = hit_mode | hit_scsel | hit_stat;

    // Layout decoder
    smcfg_decode u_dec (
        .mode_i    (serial_mode_register),
        .sc_sel_i  (smartcard_if_sel),
        .sync_o    (dec_sync),
        .char7_o   (dec_char7),
        .stop2_o   (dec_stop2),
        .mp_o      (dec_mp),
        .par_en_o  (dec_par_en),
        .par_odd_o (dec_par_odd),
        .gsm_o     (dec_gsm),
        .blk_o     (dec_blk),
        .s_o       (dec_s),
        .cks_o     (dec_cks)
    );

    // Baud-generator source prescaler
    smcfg_prescale u_pre (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cks_i  (dec_cks),
        .tick_o (pre_tick)
    );

    // Register writes; byte lane 0 carries each register
    always @(posedge clk_i) begin
        if (rst_i) begin
            serial_mode_register <= `SMCFG_MODE_RST;
            smartcard_if_sel     <= `SMCFG_SCSEL_RST;
        end else if (req && we_i && sel_i[0]) begin
            if (hit_mode) begin
                serial_mode_register <= dat_i[7:0];
            end else if (hit_scsel) begin
                smartcard_if_sel <= dat_i[0];
            end
        end
    end

    // Bus answer: one wait state, ack or err for a single cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= `SMCFG_DAT_ZERO;
        end else begin
            ack_o <= req & hit;
            err_o <= req & ~hit;
            if (req && !we_i && hit_mode) begin
                dat_o <= {24'h000000, serial_mode_register};
            end else if (req && !we_i && hit_scsel) begin
                dat_o <= {31'h00000000, smartcard_if_sel};
            end else if (req && !we_i && hit_stat) begin
                // Live status: decoded mode summary
                dat_o <= {16'h0000, dec_cks, dec_blk, dec_gsm,
                          dec_par_odd, dec_par_en, dec_mp, dec_sync, 8'h00};
            end else begin
                dat_o <= `SMCFG_DAT_ZERO;
            end
        end
    end

    // Registered control outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_o           <= 1'b0;
            char7_o          <= 1'b0;
            stop2_o          <= 1'b0;
            mp_en_o          <= 1'b0;
            parity_en_o      <= 1'b0;
            parity_odd_o     <= 1'b0;
            gsm_timing_en_o  <= 1'b0;
            block_xfer_en_o  <= 1'b0;
            bit_period_o     <= `SMCFG_S_32;
            clk_sel_o        <= `SMCFG_CKS_DIV1;
            tx_end_adv_x10_o <= `SMCFG_ZERO8;
            baud_tick_o      <= 1'b0;
        end else begin
            sync_o           <= dec_sync;
            char7_o          <= dec_char7;
            stop2_o          <= dec_stop2;
            mp_en_o          <= dec_mp;
            parity_en_o      <= dec_par_en;
            parity_odd_o     <= dec_par_odd;
            gsm_timing_en_o  <= dec_gsm;
            block_xfer_en_o  <= dec_blk;
            bit_period_o     <= dec_s;
            clk_sel_o        <= dec_cks;
            // Transmit-end flag advance for the transmitter
            tx_end_adv_x10_o <= dec_gsm ? `SMCFG_GSM_ADV_X10 : `SMCFG_ZERO8;
            baud_tick_o      <= pre_tick;
        end
    end

endmodule

/* File: tb/smcfg_monitor.sv */
/* Port checker for the serial mode configuration block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module smcfg_monitor (
    input wire logic        clk_i,            // System clock
    input wire logic        rst_i,            // Synchronous reset
    input wire logic        cyc_i,            // Bus cycle
    input wire logic        stb_i,            // Bus strobe
    input wire logic [31:0] dat_o,            // Read data
    input wire logic        ack_o,            // Acknowledge
    input wire logic        err_o,            // Error answer
    input wire logic        mp_en_o,          // Multiprocessor on
    input wire logic        parity_en_o,      // Parity on
    input wire logic        parity_odd_o,     // Odd parity
    input wire logic        gsm_timing_en_o,  // GSM timing
    input wire logic [8:0]  bit_period_o,     // Clocks per bit
    input wire logic [1:0]  clk_sel_o,        // Clock select
    input wire logic [7:0]  tx_end_adv_x10_o, // Transmit-end advance
    input wire logic        baud_tick_o       // Prescaled tick
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A taken request is answered on the next edge
    chk_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("bus request not answered");
    // Acknowledge is one pulse and read data clears behind it
    chk_ack_pulse: assert property (ack_o |=> !ack_o && dat_o == 32'h0)
        else $error("acknowledge not a single pulse");
    chk_answer_excl: assert property (!(ack_o && err_o))
        else $error("acknowledge and error together");
    // Multiprocessor format never carries parity
    chk_mp_parity: assert property (mp_en_o |-> !parity_en_o)
        else $error("parity with multiprocessor mode");
    chk_odd_parity: assert property (parity_odd_o |-> parity_en_o)
        else $error("odd parity without parity");
    chk_gsm_advance: assert property (tx_end_adv_x10_o == (gsm_timing_en_o ? 8'h6e : 8'h00))
        else $error("wrong transmit-end advance");
    chk_period_legal: assert property (bit_period_o inside {9'h020, 9'h040, 9'h174, 9'h100})
        else $error("illegal bit period");
    // Undivided source ticks every cycle once settled
    chk_tick_div1: assert property ((clk_sel_o == 2'h0)[*4] |-> baud_tick_o)
        else $error("undivided tick missing");
    chk_tick_div4: assert property (baud_tick_o && clk_sel_o == 2'h1 |=> (!baud_tick_o || clk_sel_o != 2'h1)[*3])
        else $error("divide by four tick too early");
    chk_tick_div64: assert property (baud_tick_o && clk_sel_o == 2'h3 |=> (!baud_tick_o || clk_sel_o != 2'h3)[*8])
        else $error("divide by sixty-four tick too early");
    cover property (ack_o);
    cover property (err_o);
    cover property (mp_en_o);
    cover property (gsm_timing_en_o);
endmodule
bind smcfg_top smcfg_monitor smcfg_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .mp_en_o(mp_en_o), .parity_en_o(parity_en_o),
    .parity_odd_o(parity_odd_o), .gsm_timing_en_o(gsm_timing_en_o), .bit_period_o(bit_period_o),
    .clk_sel_o(clk_sel_o), .tx_end_adv_x10_o(tx_end_adv_x10_o), .baud_tick_o(baud_tick_o));

/* File: tb/smcfg_top_tb.sv */
/* Self-checking bench: bus accesses with pseudo-random mode bytes,
   expected answers queued and compared by a watching process.
   Assumes the block's defines header is on the include path. */
`timescale 1ns/1ns
`include "smcfg_defs.vh"
module smcfg_top_tb;
    reg         clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [3:0]  adr_i = 4'h0, sel_i = 4'h0;  // Address and lane selects
    reg  [31:0] dat_i = 32'h0;               // Write data
    wire [31:0] dat_o;                       // Read data
    wire        ack_o, err_o, sync_o, char7_o, stop2_o, mp_en_o, parity_en_o, parity_odd_o;
    wire        gsm_timing_en_o, block_xfer_en_o, baud_tick_o;
    wire [8:0]  bit_period_o;                // Clocks per bit
    wire [1:0]  clk_sel_o;                   // Clock select
    wire [7:0]  tx_end_adv_x10_o;            // Transmit-end advance
    wire [18:0] outs = {sync_o, char7_o, stop2_o, mp_en_o, parity_en_o, parity_odd_o,
                        gsm_timing_en_o, block_xfer_en_o, bit_period_o, clk_sel_o};
    int         failures = 0, checked = 0, i, tk;
    reg  [53:0] notes[$];                    // Kind, error, read data, outputs
    reg  [53:0] nt;                          // Note being checked
    reg  [18:0] po, pm;                      // Pending outputs and mask
    reg         pend = 1'b0;                 // Output check due
    reg  [7:0]  lf = 8'h45, m_mode = 8'h00;  // Random state and mode model
    reg         m_sc = 1'b0, sc_n = 1'b0;    // Layout model and next layout
    smcfg_top smcfg_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .sync_o(sync_o), .char7_o(char7_o), .stop2_o(stop2_o), .mp_en_o(mp_en_o),
        .parity_en_o(parity_en_o), .parity_odd_o(parity_odd_o), .gsm_timing_en_o(gsm_timing_en_o),
        .block_xfer_en_o(block_xfer_en_o), .bit_period_o(bit_period_o), .clk_sel_o(clk_sel_o),
        .tx_end_adv_x10_o(tx_end_adv_x10_o), .baud_tick_o(baud_tick_o));
    // Clock at 50 MHz
    always #10 clk_i = ~clk_i;
    // Next value of the eight-bit pseudo-random sequence
    function [7:0] lfsr(input [7:0] l);
        lfsr = {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
    endfunction
    // Outputs expected from a mode byte and a layout
    function [18:0] exp_outs(input [7:0] m, input s);
        reg sy, mp, pe;
        reg [8:0] sv;
        begin
            sy = !s & m[7];
            mp = !s & !sy & m[2];
            pe = s ? m[5] : (!sy & !mp & m[5]);
            case (m[3:2])
                2'h0: sv = 9'h020;
                2'h1: sv = 9'h040;
                2'h2: sv = 9'h174;
                default: sv = 9'h100;
            endcase
            // Normal layout always reports the smallest period
            if (!s) sv = 9'h020;
            exp_outs = {sy, !s & !sy & m[6], !s & !sy & m[3], mp, pe, pe & m[4], s & m[7], s & m[6], sv, m[1:0]};
        end
    endfunction
    // One compare, counted
    task check(input [31:0] got, input [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ends the run with the verdict
    task print_verdict;
        if (failures == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One classic bus cycle, held until the answer is sampled
    task bus(input w, input [3:0] a, input [31:0] d, input [3:0] sl);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= sl;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask
    // Access with its expected answer noted first
    task acc(input w, input [3:0] a, input [31:0] d, input [3:0] sl);
        reg e;
        reg [1:0] k;
        reg [18:0] eo;
        e = !(a == `SMCFG_ADR_MODE || a == `SMCFG_ADR_SCSEL || a == `SMCFG_ADR_STATUS);
        if (w && sl[0] && a == `SMCFG_ADR_MODE) m_mode = d[7:0];
        if (w && sl[0] && a == `SMCFG_ADR_SCSEL) m_sc = d[0];
        k = e ? 2'h0 : (!w ? 2'h1 : (m_sc ? 2'h2 : 2'h3));
        eo = exp_outs(m_mode, m_sc);
        // Status word: clock select, block, GSM, odd, parity, multiprocessor, synchronous
        notes.push_back({k, e, (a == `SMCFG_ADR_MODE) ? {24'h0, m_mode} : (a == `SMCFG_ADR_STATUS) ?
            {16'h0, eo[1:0], eo[11], eo[12], eo[13], eo[14], eo[15], eo[18], 8'h0} : {31'h0, m_sc}, eo});
        bus(w, a, d, sl);
    endtask
    // Watches answers and takes the oldest note for each
    always @(posedge clk_i) begin
        if (pend) check({13'h0, outs & pm}, {13'h0, po & pm});
        if (pend) check({24'h0, tx_end_adv_x10_o}, {24'h0, po[12] ? `SMCFG_GSM_ADV_X10 : `SMCFG_ZERO8});
        pend = 1'b0;
        if (ack_o === 1'b1 || err_o === 1'b1) begin
            nt = (notes.size() > 0) ? notes.pop_front() : ~54'h0;
            check({31'h0, err_o}, {31'h0, nt[51]});
            if (nt[53:52] == 2'h1) check(dat_o, nt[50:19]);
            pend = nt[53];
            po = nt[18:0];
            pm = 19'h7ffff;
        end
    end
    // Cuts a hang short
    initial begin
        #(20 * 30000);
        failures++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, `SMCFG_ADR_MODE, 32'h0, 4'hf);
        acc(0, `SMCFG_ADR_SCSEL, 32'h0, 4'hf);
        // Each clock select held long enough to watch its ticks
        for (i = 0; i < 4; i++) begin
            acc(1, `SMCFG_ADR_MODE, i, 4'h1);
            repeat (22) @(posedge clk_i);
            // A window of 128 cycles holds an exact number of ticks
            tk = 0;
            repeat (128) begin
                @(posedge clk_i);
                tk += baud_tick_o;
            end
            check(tk, 32'd128 >> (2 * i));
        end
        // Random layouts and mode bytes, each mode byte read back with the status
        for (i = 0; i < 48; i++) begin
            lf = lfsr(lf);
            sc_n = lf[0];
            lf = lfsr(lf);
            // Parity kept on whenever smart card layout is or will be active
            acc(1, `SMCFG_ADR_MODE, {24'h0, lf | ((sc_n || m_sc) ? 8'h20 : 8'h00)}, 4'hf);
            acc(1, `SMCFG_ADR_SCSEL, {31'h0, sc_n}, 4'hf);
            acc(0, `SMCFG_ADR_MODE, 32'h0, 4'hf);
            acc(0, `SMCFG_ADR_STATUS, 32'h0, 4'hf);
        end
        // Reset in mid-run clears both registers
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m_mode = 8'h00;
        m_sc = 1'b0;
        acc(0, `SMCFG_ADR_MODE, 32'h0, 4'hf);
        acc(0, `SMCFG_ADR_SCSEL, 32'h0, 4'hf);
        // Unselected lane, read-only status, unmapped place
        acc(1, `SMCFG_ADR_MODE, 32'ha5, 4'he);
        acc(1, `SMCFG_ADR_STATUS, 32'hff00, 4'hf);
        acc(1, 4'hc, 32'h5a, 4'hf);
        acc(0, 4'hc, 32'h0, 4'hf);
        acc(0, `SMCFG_ADR_MODE, 32'h0, 4'hf);
        repeat (3) @(posedge clk_i);
        print_verdict;
    end
endmodule
